//--- src/rbs_pkg.sv
// constants, types and the boot decode for the reset and boot select block
// Function
// - five reset sources each force reset
// - latch boot pins when reset sequence ends
// - only power-on or pin reset reload boot
// - auto loader: no password, byte zero zero
// - can loader bypasses the oscillator
// - one option: user mode with debug pins
// - boot options honoured only with default pins
// - power mode register, reset-cause flags, zero reset
// - event status flags, bit 7 reads zero
// - key register: write key, state, mode
`default_nettype none
package rbs_pkg;
  // register addresses on the special function bus
  localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'hb3;
  localparam logic [7:0] ADDR_POWER_MODE    = 8'hb4;
  localparam logic [7:0] ADDR_PROT_KEY      = 8'hbb;
  localparam logic [7:0] ADDR_NMI_STATUS    = 8'hbc;
  // values after reset
  localparam logic [7:0] RST_POWER_MODE = 8'h00;
  localparam logic [7:0] RST_PROT_KEY   = 8'h07;
  localparam logic [7:0] RST_NMI_STATUS = 8'h00;
  // power mode field positions
  localparam int PM_WDOG_RST_BIT = 6;
  localparam int PM_WAKE_RST_BIT = 5;
  localparam int PM_WAKE_SEL_BIT = 4;
  localparam int PM_PDOWN_BIT    = 2;
  localparam logic [7:0] PM_WR_MASK  = 8'h7f;
  // event status layout, bit 7 reserved
  localparam int NMI_EVENTS = 7;
  localparam logic [7:0] NMI_WR_MASK = 8'h7f;
  // key register layout
  localparam int KEY_LSB  = 3;
  localparam int PROT_BIT = 2;
  // reset exit sequence length in cycles
  localparam logic [4:0] EXIT_CYCLES = 5'h10;
  // partner side pin low time at power-up
  localparam int PIN_LOW_US = 500;

  // internal reset sequencer states
  typedef enum logic [1:0] {ST_HOLD, ST_EXIT, ST_RUN} rbs_state_type;

  // boot options selected by the latched pins
  typedef enum logic [2:0] {
    BOOT_USER, BOOT_USER_JTAG, BOOT_LOADER_UART, BOOT_LOADER_CAN
  } rbs_boot_type;

  // decode of {boot_control_pin, cfg[1:0]}
  function automatic rbs_boot_type rbs_decode_boot(input logic [2:0] pins);
    rbs_boot_type opt;
    opt = BOOT_USER;
    if (!pins[2]) begin
      case (pins[1:0])
        2'b00:   opt = BOOT_LOADER_UART;
        2'b01:   opt = BOOT_LOADER_CAN;
        default: opt = BOOT_USER_JTAG;
      endcase
    end
    return opt;
  endfunction : rbs_decode_boot
endpackage : rbs_pkg
`default_nettype wire

//--- src/rbs_sync.sv
// two flip-flop synchroniser for pin levels
`default_nettype none
`timescale 1ns/1ps
module rbs_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;  // first stage, read only by second stage

  // both stages take the constant under reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : rbs_sync
`default_nettype wire

//--- src/rbs_top.sv
// reset source sequencer, boot option latch and system control registers
`default_nettype none
`timescale 1ns/1ps
module rbs_top
  import rbs_pkg::*;
#(
  parameter logic [4:0] PRODUCT_CODE  = 5'h05,  // arbitrary value
  parameter logic [2:0] REVISION_CODE = 3'h1    // arbitrary value
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   reset_pin_n_i,
  input  wire logic                   brownout_i,
  input  wire logic                   watchdog_timeout_i,
  input  wire logic                   wakeup_reset_i,
  input  wire logic                   boot_control_pin_i,
  input  wire logic [1:0]             boot_cfg_pins_i,
  input  wire logic                   default_pin_map_i,
  input  wire logic                   password_valid_i,
  input  wire logic                   flash_byte0_zero_i,
  input  wire logic [rbs_pkg::NMI_EVENTS-1:0] nmi_event_i,
  input  wire logic [7:0]             sfr_addr_i,
  input  wire logic                   sfr_wr_i,
  input  wire logic                   sfr_rd_i,
  input  wire logic [7:0]             sfr_wdata_i,
  output logic      [7:0]             sfr_rdata_o,
  output logic                        sys_reset_o,
  output rbs_pkg::rbs_boot_type       boot_option_o,
  output logic                        bootstrap_loader_mode_o,
  output logic                        osc_bypass_o,
  output logic                        jtag_enable_o,
  output logic                        boot_defined_o,
  output logic                        power_down_req_o,
  output logic                        wakeup_source_select_o,
  output logic      [1:0]             protect_mode_o,
  output logic      [4:0]             protection_key_o
);
  import rbs_pkg::*;

  // synchronised pins: {reset_pin_n, brownout, boot_control_pin, cfg}
  logic [4:0] pins_s;
  rbs_sync #(.WIDTH(5), .RESET_VAL(5'h14)) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({reset_pin_n_i, brownout_i, boot_control_pin_i, boot_cfg_pins_i}),
    .sync_o     (pins_s)
  );

  logic pin_rst;   // external pin held low
  logic brown_rst; // supply below threshold
  logic any_src;   // any warm or pin source active
  assign pin_rst   = ~pins_s[4];
  assign brown_rst = pins_s[3];
  assign any_src   = pin_rst | brown_rst | watchdog_timeout_i | wakeup_reset_i;

  // sequencer state
  rbs_state_type state, next_state;
  logic [4:0]    exit_cnt, next_exit_cnt;
  logic          cold, next_cold;       // pending boot reload
  logic          exit_done;             // last exit cycle

  // boot latch state
  rbs_boot_type  boot_option, next_boot_option;
  logic          boot_defined, next_boot_defined;
  logic          auto_loader, next_auto_loader;

  // registers
  logic [7:0]    power_mode, next_power_mode;
  logic [7:0]    nmi_status, next_nmi_status;
  logic [1:0]    prot_mode, next_prot_mode;
  logic [4:0]    prot_key, next_prot_key;
  logic          prot_state, next_prot_state;
  logic [7:0]    rdata, next_rdata;

  // access strobes
  logic wr_pm, wr_key, wr_nmi;
  assign wr_pm  = sfr_wr_i && (sfr_addr_i == ADDR_POWER_MODE);
  assign wr_key = sfr_wr_i && (sfr_addr_i == ADDR_PROT_KEY);
  assign wr_nmi = sfr_wr_i && (sfr_addr_i == ADDR_NMI_STATUS);
  assign exit_done = (state == ST_EXIT) && (exit_cnt == EXIT_CYCLES - 5'h01);

  // reset sequencer next state
  always_comb begin
    next_state    = state;
    next_exit_cnt = exit_cnt;
    next_cold     = cold | pin_rst;
    case (state)
      ST_HOLD: begin
        next_exit_cnt = 5'h00;
        if (!any_src) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (any_src) begin
          next_state    = ST_HOLD;
          next_exit_cnt = 5'h00;
        end else if (exit_done) begin
          next_state = ST_RUN;
          next_cold  = 1'b0;
        end else begin
          next_exit_cnt = 5'(exit_cnt + 5'h01);
        end
      end
      default: begin
        if (any_src) begin
          next_state = ST_HOLD;
        end
      end
    endcase
  end

  // sequencer registers, power-on reset is a cold start
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state    <= ST_HOLD;
      exit_cnt <= 5'h00;
      cold     <= 1'b1;
    end else begin
      state    <= next_state;
      exit_cnt <= next_exit_cnt;
      cold     <= next_cold;
    end
  end

  // boot latch next values
  always_comb begin
    next_boot_option  = boot_option;
    next_boot_defined = boot_defined;
    next_auto_loader  = auto_loader;
    if (exit_done && !any_src) begin
      if (cold) begin
        next_boot_option  = rbs_decode_boot(pins_s[2:0]);
        next_boot_defined = default_pin_map_i;
      end
      next_auto_loader = !password_valid_i && flash_byte0_zero_i;
    end
  end

  // boot latch registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      boot_option  <= BOOT_USER;
      boot_defined <= 1'b0;
      auto_loader  <= 1'b0;
    end else begin
      boot_option  <= next_boot_option;
      boot_defined <= next_boot_defined;
      auto_loader  <= next_auto_loader;
    end
  end

  // register next values, hardware set wins over a software clear
  always_comb begin
    next_power_mode = power_mode;
    next_nmi_status = nmi_status;
    next_prot_mode  = prot_mode;
    next_prot_key   = prot_key;
    next_prot_state = password_valid_i;
    if (wr_pm) begin
      next_power_mode = sfr_wdata_i & PM_WR_MASK;
    end
    if (wakeup_reset_i) begin
      next_power_mode[PM_PDOWN_BIT] = 1'b0;            // wake ends power-down
    end
    if (watchdog_timeout_i && state != ST_HOLD) begin
      next_power_mode[PM_WDOG_RST_BIT] = 1'b1;
    end
    if (wakeup_reset_i && state != ST_HOLD) begin
      next_power_mode[PM_WAKE_RST_BIT] = 1'b1;
    end
    if (wr_nmi) begin
      next_nmi_status = sfr_wdata_i & NMI_WR_MASK;
    end
    next_nmi_status[NMI_EVENTS-1:0] = next_nmi_status[NMI_EVENTS-1:0] | nmi_event_i;
    if (wr_key) begin
      next_prot_key  = sfr_wdata_i[7:KEY_LSB];
      next_prot_mode = sfr_wdata_i[1:0];
    end
  end

  // read data next value, unmapped reads zero
  always_comb begin
    next_rdata = rdata;
    if (sfr_rd_i) begin
      if (sfr_addr_i == ADDR_CHIP_IDENTITY) begin
        next_rdata = {PRODUCT_CODE, REVISION_CODE};
      end else if (sfr_addr_i == ADDR_POWER_MODE) begin
        next_rdata = power_mode;
      end else if (sfr_addr_i == ADDR_PROT_KEY) begin
        next_rdata = {5'h00, prot_state, prot_mode};   // key reads zero
      end else if (sfr_addr_i == ADDR_NMI_STATUS) begin
        next_rdata = nmi_status;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // register file flops
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      power_mode <= RST_POWER_MODE;
      nmi_status <= RST_NMI_STATUS;
      prot_mode  <= RST_PROT_KEY[1:0];
      prot_state <= RST_PROT_KEY[PROT_BIT];
      prot_key   <= RST_PROT_KEY[7:KEY_LSB];
      rdata      <= 8'h00;
    end else begin
      power_mode <= next_power_mode;
      nmi_status <= next_nmi_status;
      prot_mode  <= next_prot_mode;
      prot_state <= next_prot_state;
      prot_key   <= next_prot_key;
      rdata      <= next_rdata;
    end
  end

  // output flops
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sys_reset_o             <= 1'b1;
      boot_option_o           <= BOOT_USER;
      bootstrap_loader_mode_o <= 1'b0;
      osc_bypass_o            <= 1'b0;
      jtag_enable_o           <= 1'b0;
      boot_defined_o          <= 1'b0;
      power_down_req_o        <= 1'b0;
      wakeup_source_select_o  <= 1'b0;
      protect_mode_o          <= RST_PROT_KEY[1:0];
      protection_key_o        <= RST_PROT_KEY[7:KEY_LSB];
      sfr_rdata_o             <= 8'h00;
    end else begin
      sys_reset_o             <= (next_state != ST_RUN);
      boot_option_o           <= next_boot_option;
      bootstrap_loader_mode_o <= next_auto_loader | (next_boot_defined &&
        (next_boot_option == BOOT_LOADER_UART || next_boot_option == BOOT_LOADER_CAN));
      osc_bypass_o            <= next_boot_defined && (next_boot_option == BOOT_LOADER_CAN);
      jtag_enable_o           <= next_boot_defined && (next_boot_option == BOOT_USER_JTAG);
      boot_defined_o          <= next_boot_defined;
      power_down_req_o        <= next_power_mode[PM_PDOWN_BIT];
      wakeup_source_select_o  <= next_power_mode[PM_WAKE_SEL_BIT];
      protect_mode_o          <= next_prot_mode;
      protection_key_o        <= next_prot_key;
      sfr_rdata_o             <= next_rdata;
    end
  end

  // check helper: cycles spent in the exit state so far
  logic [4:0] exit_seen, next_exit_seen;

  // counts while in exit, clears anywhere else
  always_comb begin
    next_exit_seen = 5'h00;
    if (state == ST_EXIT) begin
      next_exit_seen = 5'(exit_seen + 5'h01);
    end
  end

  // check helper register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      exit_seen <= 5'h00;
    end else begin
      exit_seen <= next_exit_seen;
    end
  end

  // checks
  a_src_forces_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    any_src |=> state == ST_HOLD) else $error("source did not hold reset");
  a_exit_length: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && exit_seen != 5'h00 |-> exit_seen == EXIT_CYCLES)
    else $error("exit sequence length wrong");
  a_warm_keeps_boot: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !cold && !pin_rst |=> $stable(boot_option)) else $error("boot changed on warm reset");
  a_boot_latched: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exit_done && !any_src && cold |=> boot_option == rbs_decode_boot($past(pins_s[2:0])))
    else $error("boot pins not latched");
  a_can_bypass: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 osc_bypass_o |-> boot_defined && boot_option == BOOT_LOADER_CAN)
    else $error("bypass without can loader");
  a_auto_loader: assert property (@(posedge core_clk_i) disable iff (rst_i)
    exit_done && !any_src && !password_valid_i && flash_byte0_zero_i
    |=> ##1 bootstrap_loader_mode_o)
    else $error("auto loader not entered");
  a_nmi_set_wins: assert property (@(posedge core_clk_i) disable iff (rst_i)
    nmi_event_i[0] |=> nmi_status[0]) else $error("event flag lost");
  a_nmi_bit7_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    1'b1 |=> !nmi_status[7]) else $error("reserved bit set");
  a_wdog_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    watchdog_timeout_i && state == ST_RUN |=> power_mode[PM_WDOG_RST_BIT] && state == ST_HOLD)
    else $error("watchdog cause not recorded");
  a_jtag_defined: assert property (@(posedge core_clk_i) disable iff (rst_i)
    jtag_enable_o |-> boot_defined_o) else $error("debug pins on undefined map");
endmodule : rbs_top
`default_nettype wire

//--- testbench/rbs_pin_model.sv
// board side model: reset pin driver with pull-up and boot strap pins
`timescale 1ns/1ps
`default_nettype none
module rbs_pin_model #(
  parameter int LOW_CYCLES = 20  // shortened pin low time for simulation
) (
  input  wire logic       core_clk_i,
  input  wire logic       pin_req_i,    // one cycle request for a pin reset
  input  wire logic [2:0] boot_i,       // strap levels {control, cfg1, cfg0}
  output logic            reset_pin_n_o,
  output logic            boot_control_pin_o,
  output logic [1:0]      boot_cfg_pins_o
);
  int cnt = 0;  // remaining low cycles
  // hold the pin low for the full time, else the pull-up wins
  always @(posedge core_clk_i) begin
    if (pin_req_i) cnt <= LOW_CYCLES;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign reset_pin_n_o = (cnt == 0);
  // straps sit on the default pin map positions
  assign boot_control_pin_o = boot_i[2];
  assign boot_cfg_pins_o    = boot_i[1:0];
endmodule : rbs_pin_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the reset and boot select block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rbs_pkg::*;
  logic clk = 0, rst = 1, pin_req = 0, brown = 0, wdog = 0, wake = 0, pmap = 1, pwd = 1, b0z = 0;
  logic [2:0] boot_pins = 3'h4;
  logic [6:0] nmi = '0;
  logic [7:0] addr = '0, wdata = '0, rdata;
  logic wr = 0, rd = 0, pin_n, bctl, sysr, bootstrap_loader_mode, osc, jtag, bdef, pdn, wsel;
  logic [1:0] cfg, pmode;
  logic [4:0] key;
  rbs_boot_type bopt;
  int num_errors = 0, n_checks = 0, cyc = 0, falls = 0;
  always #4 clk = ~clk;
  rbs_pin_model pm (.core_clk_i(clk), .pin_req_i(pin_req), .boot_i(boot_pins),
    .reset_pin_n_o(pin_n), .boot_control_pin_o(bctl), .boot_cfg_pins_o(cfg));
  // identity codes are arbitrary
  rbs_top #(.PRODUCT_CODE(5'h0a), .REVISION_CODE(3'h2)) dut (.core_clk_i(clk), .rst_i(rst),
    .reset_pin_n_i(pin_n), .brownout_i(brown), .watchdog_timeout_i(wdog),
    .wakeup_reset_i(wake), .boot_control_pin_i(bctl), .boot_cfg_pins_i(cfg),
    .default_pin_map_i(pmap), .password_valid_i(pwd), .flash_byte0_zero_i(b0z),
    .nmi_event_i(nmi), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sys_reset_o(sysr), .boot_option_o(bopt),
    .bootstrap_loader_mode_o(bootstrap_loader_mode), .osc_bypass_o(osc), .jtag_enable_o(jtag),
    .boot_defined_o(bdef), .power_down_req_o(pdn), .wakeup_source_select_o(wsel),
    .protect_mode_o(pmode), .protection_key_o(key));
  // count reset exits and cut a hang short
  always @(negedge sysr) falls++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one cycle write strobe, visible the next cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 check(what, rdata, exp);
  endtask : rd_chk
  // bounded wait: up to 40 cycles for reset to rise, then the exit sequence must end
  task automatic wait_run();
    int i;
    for (i = 0; i < 40 && !sysr; i++) #1 @(posedge clk);
    for (i = 0; i < 200 && sysr !== 1'b0; i++) @(posedge clk);
    #1 check("exit", {7'h0, sysr}, 8'h00);
  endtask : wait_run
  task automatic pin_reset(input logic [2:0] p);
    @(posedge clk);
    boot_pins <= p; pin_req <= 1'b1;
    @(posedge clk);
    pin_req <= 1'b0;
    wait_run();
  endtask : pin_reset
  // one source for three cycles: 0 watchdog, 1 wake-up, 2 brownout
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) wdog <= 1'b1;
    else if (which == 1) wake <= 1'b1;
    else brown <= 1'b1;
    tick(3);
    wdog <= 1'b0; wake <= 1'b0; brown <= 1'b0;
    wait_run();
  endtask : pulse
  task automatic t_reset_values();
    rd_chk("pmode", ADDR_POWER_MODE, 8'h00);
    rd_chk("key", ADDR_PROT_KEY, 8'h07);
    rd_chk("nmi", ADDR_NMI_STATUS, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr_reg(ADDR_CHIP_IDENTITY, 8'hff);
    rd_chk("ident", ADDR_CHIP_IDENTITY, 8'h52);
    $display("done reset values");
  endtask : t_reset_values
  // every boot option except plain user mode from a pin reset
  task automatic t_cold_boot();
    logic [2:0] pins [3] = '{3'h1, 3'h2, 3'h0};
    rbs_boot_type exp [3] = '{BOOT_LOADER_CAN, BOOT_USER_JTAG, BOOT_LOADER_UART};
    for (int i = 0; i < 3; i++) begin
      pin_reset(pins[i]);
      check("option", {5'h0, bopt}, {5'h0, exp[i]});
      check("bypass", {7'h0, osc}, {7'h0, i == 0});
      check("jtag", {7'h0, jtag}, {7'h0, i == 1});
      check("loader", {7'h0, bootstrap_loader_mode}, {7'h0, i != 1});
    end
    $display("done cold boot");
  endtask : t_cold_boot
  // watchdog and brownout resets keep the latched option, watchdog and wake-up log their cause
  task automatic t_warm_keep();
    boot_pins <= 3'h1;
    pulse(0);
    check("keep wdog", {5'h0, bopt}, {5'h0, BOOT_LOADER_UART});
    rd_chk("wdog flag", ADDR_POWER_MODE, 8'h40);
    wr_reg(ADDR_POWER_MODE, 8'h14);
    check("pdown", {6'h0, pdn, wsel}, 8'h03);
    pulse(1);
    rd_chk("wake flag", ADDR_POWER_MODE, 8'h30);
    check("pdown clr", {6'h0, pdn, wsel}, 8'h01);
    pulse(2);
    check("keep brown", {5'h0, bopt}, {5'h0, BOOT_LOADER_UART});
    $display("done warm keep");
  endtask : t_warm_keep
  task automatic t_overlap();
    int f;
    f = falls;
    @(posedge clk);
    wdog <= 1'b1;
    tick(4);
    brown <= 1'b1;
    tick(4);
    wdog <= 1'b0;
    tick(10);
    brown <= 1'b0;
    wait_run();
    check("exits", 8'(falls - f), 8'h01);
    $display("done overlap");
  endtask : t_overlap
  task automatic t_auto_and_map();
    pin_reset(3'h4);
    pwd <= 1'b0; b0z <= 1'b1;
    pulse(0);
    check("auto", {7'h0, bootstrap_loader_mode}, 8'h01);
    check("user", {5'h0, bopt}, {5'h0, BOOT_USER});
    pwd <= 1'b1; b0z <= 1'b0; pmap <= 1'b0;
    pin_reset(3'h1);
    check("defined", {6'h0, bdef, osc}, 8'h00);
    pmap <= 1'b1;
    $display("done auto and map");
  endtask : t_auto_and_map
  task automatic t_events_key();
    @(posedge clk);
    nmi <= 7'h7f;
    @(posedge clk);
    nmi <= 7'h00;
    wr_reg(ADDR_NMI_STATUS, 8'hff);
    rd_chk("events", ADDR_NMI_STATUS, 8'h7f);
    wr_reg(ADDR_NMI_STATUS, 8'h00);
    rd_chk("ev clr", ADDR_NMI_STATUS, 8'h00);
    wr_reg(ADDR_PROT_KEY, 8'hf9);
    check("key out", {1'b0, key, pmode}, 8'h7d);
    @(posedge clk);
    addr <= ADDR_PROT_KEY; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 check("key rd", rdata & 8'hfb, 8'h01);
    $display("done events and key");
  endtask : t_events_key
  initial begin
    tick(2);
    rst <= 1'b0;
    wait_run();
    t_reset_values();
    t_cold_boot();
    t_warm_keep();
    t_overlap();
    t_auto_and_map();
    t_events_key();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
